// file: logic/pcf_pkg.sv
// Constants, carriers and states of the peak current fold-back block.
// Assumes one 100 MHz clock and currents in whole amperes.
// Summary of operation
// - Current limit output never exceeds the programmed peak current.
// - Rated current in the fold-back arithmetic is a fixed 12 A.
// - Measured current above continuous setting integrates the accumulator up.
// - Measured current below continuous setting integrates the accumulator down.
// - At the accumulator limit the current limit drops to the continuous setting, if that is below the peak setting.
// - Allowed peak time in ms is 1512000 over peak squared minus rated squared.
// - Programmed peak current is clamped to at most 30 A.
// - A peak time within the allowed time is used unchanged.
// - A peak time beyond the allowed time is replaced by the allowed time.
// - Effective peak time never exceeds 30 seconds.
package pcf_pkg;
	localparam int CLK_MHZ    = 100;
	localparam int SAMPLE_US  = 1000;
	localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
	localparam int CUR_W      = 8;
	localparam int SQ_W       = 16;
	localparam int ACC_W      = 21;
	localparam int TIME_W     = 16;
	localparam int DVS_W      = 10;
	localparam logic [CUR_W-1:0]  RATED_I   = 8'h0C;
	localparam logic [SQ_W-1:0]   RATED_SQ  = SQ_W'(RATED_I) * SQ_W'(RATED_I);
	localparam logic [CUR_W-1:0]  PEAK_MAX  = 8'h1E;
	localparam logic [ACC_W-1:0]  ACC_LIMIT = 21'h171240;
	localparam logic [TIME_W-1:0] TIME_MAX  = 16'h7530;
	localparam logic [7:0]        OFS_CTRL  = 8'h00;
	localparam logic [7:0]        OFS_CONT  = 8'h04;
	localparam logic [7:0]        OFS_PEAK  = 8'h08;
	localparam logic [7:0]        OFS_PTIME = 8'h0C;
	localparam logic [7:0]        OFS_ETIME = 8'h10;
	localparam logic [7:0]        OFS_STAT  = 8'h14;
	localparam logic [7:0]        OFS_ACC   = 8'h18;
	localparam logic [7:0]        OFS_NONE  = 8'hFF;
	localparam int                EN_BIT    = 0;
	localparam int                FOLD_BIT  = 0;
	localparam int                BUSY_BIT  = 1;
	localparam logic [CUR_W-1:0]  CONT_RST  = 8'h0A;
	localparam logic [CUR_W-1:0]  PEAK_RST  = 8'h1E;
	localparam logic [TIME_W-1:0] PTIME_RST = 16'h07D0;
	localparam logic [2:0]        HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic              enable;
		logic [CUR_W-1:0]  cont_i;
		logic [CUR_W-1:0]  peak_i;
		logic [TIME_W-1:0] peak_t;
	} pcf_cfg_t;

	localparam pcf_cfg_t CFG_RST = '{enable: 1'b0, cont_i: CONT_RST, peak_i: PEAK_RST, peak_t: PTIME_RST};

	typedef enum logic [1:0] {
		RC_IDLE = 2'b00,
		RC_KICK = 2'b01,
		RC_RUN  = 2'b10
	} pcf_rc_t;
endpackage : pcf_pkg

// file: logic/pcf_div.sv
// Iterative restoring divider, one quotient bit per clock.
// Assumes start is only honoured while busy is low.
`timescale 1ns/1ps
module pcf_div #(
	parameter int N = 21,
	parameter int D = 10
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         start,
	input  wire logic [N-1:0] dividend,
	input  wire logic [D-1:0] divisor,
	output logic [N-1:0]      quo,
	output logic              busy,
	output logic              done
);
	import pcf_pkg::*;
	localparam int CW = $clog2(N + 1);
	typedef struct packed {
		logic          busy;
		logic          done;
		logic [CW-1:0] cnt;
		logic [D:0]    rem;
		logic [N-1:0]  quo;
		logic [D-1:0]  dvs;
	} pcf_div_st_t;
	pcf_div_st_t st;
	pcf_div_st_t next_st;
	logic [D:0]  trial;

	if (N < 2 || D < 1) begin : g_chk
		$error("pcf_div: widths too small");
	end

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		trial = {st.rem[D-1:0], st.quo[N-1]};
		if (start && !st.busy) begin
			next_st.busy = 1'b1;
			next_st.cnt = CW'(N);
			next_st.rem = '0;
			next_st.quo = dividend;
			next_st.dvs = divisor;
		end else if (st.busy) begin
			next_st.quo = {st.quo[N-2:0], 1'b0};
			if (trial >= {1'b0, st.dvs}) begin
				next_st.rem = trial - {1'b0, st.dvs};
				next_st.quo[0] = 1'b1;
			end else begin
				next_st.rem = trial;
			end
			next_st.cnt = st.cnt - 1'b1;
			if (st.cnt == CW'(1)) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign quo  = st.quo;
	assign busy = st.busy;
	assign done = st.done;

	sequence s_div_go;
		start && !st.busy;
	endsequence

	div_latency_a: assert property (@(posedge clk) disable iff (rst)
		s_div_go |-> ##(N + 1) st.done)
		else $error("divider did not finish on time");
	div_remainder_a: assert property (@(posedge clk) disable iff (rst)
		st.done |-> st.rem < {1'b0, st.dvs})
		else $error("divider remainder not below divisor");
endmodule : pcf_div

// file: logic/pcf_integ.sv
// Squared-current integrator with a fixed sample period.
// Assumes measured current and settings are magnitudes in amperes.
`timescale 1ns/1ps
module pcf_integ #(
	parameter int SAMPLE_CYC = pcf_pkg::SAMPLE_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire pcf_pkg::pcf_cfg_t       cfg,
	input  wire logic [pcf_pkg::CUR_W-1:0] cur,
	output logic [pcf_pkg::ACC_W-1:0]    acc,
	output logic                         folded
);
	import pcf_pkg::*;
	localparam int CNT_W = $clog2(SAMPLE_CYC);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [ACC_W-1:0] acc;
		logic             folded;
	} pcf_integ_st_t;
	pcf_integ_st_t    st;
	pcf_integ_st_t    next_st;
	logic             tick;
	logic [SQ_W-1:0]  sq_i;
	logic [SQ_W-1:0]  sq_c;
	logic [ACC_W-1:0] up;
	logic [ACC_W-1:0] dn;

	if (SAMPLE_CYC < 2) begin : g_chk
		$error("pcf_integ: sample period too short");
	end

	always_comb begin
		next_st = st;
		tick = st.cnt == CNT_W'(SAMPLE_CYC - 1);
		sq_i = SQ_W'(cur) * SQ_W'(cur);
		sq_c = SQ_W'(cfg.cont_i) * SQ_W'(cfg.cont_i);
		// Step of one keeps the sum moving when squares tie or the difference would be negative
		up = (sq_i > RATED_SQ) ? ACC_W'(sq_i - RATED_SQ) : ACC_W'(1);
		dn = (sq_c > sq_i) ? ACC_W'(sq_c - sq_i) : ACC_W'(1);
		next_st.cnt = tick ? '0 : st.cnt + 1'b1;
		if (!cfg.enable) begin
			next_st.acc = '0;
		end else if (tick) begin
			if (cur > cfg.cont_i) begin
				next_st.acc = (ACC_LIMIT - st.acc <= up) ? ACC_LIMIT : st.acc + up;
			end else if (cur < cfg.cont_i) begin
				next_st.acc = (st.acc <= dn) ? '0 : st.acc - dn;
			end
		end
		// No hysteresis: one step down releases the fold
		next_st.folded = next_st.acc == ACC_LIMIT;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign acc    = st.acc;
	assign folded = st.folded;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	acc_ceiling_a: assert property (st.acc <= ACC_LIMIT)
		else $error("accumulator above limit");
	acc_hold_a: assert property (!tick && cfg.enable |=> $stable(st.acc))
		else $error("accumulator moved between samples");
	integ_up_a: assert property (tick && cfg.enable && cur > cfg.cont_i && st.acc < ACC_LIMIT
		|=> st.acc > $past(st.acc))
		else $error("accumulator did not rise");
	integ_down_a: assert property (tick && cfg.enable && cur < cfg.cont_i && st.acc != '0
		|=> st.acc < $past(st.acc))
		else $error("accumulator did not fall");
	fold_flag_a: assert property (st.folded == (st.acc == ACC_LIMIT))
		else $error("fold flag disagrees with accumulator");
endmodule : pcf_integ

// file: logic/pcf_top.sv
// Peak current fold-back: AHB-Lite registers, integrator, time check.
// Assumes a single AHB-Lite master and a current sample each clock.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module pcf_top #(
	parameter int SAMPLE_CYC = pcf_pkg::SAMPLE_CYC
) (
	input  wire logic                        MCLK,
	input  wire logic                        SYS_RST,
	input  wire logic                        HSEL,
	input  wire logic [31:0]                 HADDR,
	input  wire logic [1:0]                  HTRANS,
	input  wire logic                        HWRITE,
	input  wire logic [2:0]                  HSIZE,
	input  wire logic [31:0]                 HWDATA,
	input  wire logic                        HREADY,
	output logic [31:0]                      HRDATA,
	output logic                             HREADYOUT,
	output logic                             HRESP,
	input  wire logic [pcf_pkg::CUR_W-1:0]   CUR_MEAS,
	output logic [pcf_pkg::CUR_W-1:0]        I_LIMIT,
	output logic                             FOLDED
);
	import pcf_pkg::*;

	typedef struct packed {
		pcf_cfg_t          cfg;
		pcf_rc_t           rc;
		logic [TIME_W-1:0] eff_t;
		logic [7:0]        addr;
		logic              wr_pend;
		logic              rd_pend;
		logic [31:0]       hrdata;
		logic              hready;
		logic              hresp;
		logic [CUR_W-1:0]  ilim;
		logic              folded;
	} pcf_top_st_t;

	pcf_top_st_t       st;
	pcf_top_st_t       next_st;
	logic [31:0]       rd_val;
	logic [SQ_W-1:0]   peak_sq;
	logic [TIME_W-1:0] allow_t;
	logic              div_start;
	logic              div_busy;
	logic              div_done;
	logic [ACC_W-1:0]  div_quo;
	logic [ACC_W-1:0]  acc;
	logic              fold;

	if (SAMPLE_CYC < 2) begin : g_chk
		$error("pcf_top: sample period too short");
	end

	pcf_integ #(
		.SAMPLE_CYC (SAMPLE_CYC)
	) u_integ (
		.clk    (MCLK),
		.rst    (SYS_RST),
		.cfg    (st.cfg),
		.cur    (CUR_MEAS),
		.acc    (acc),
		.folded (fold)
	);

	pcf_div #(
		.N (ACC_W),
		.D (DVS_W)
	) u_div (
		.clk      (MCLK),
		.rst      (SYS_RST),
		.start    (div_start),
		.dividend (ACC_LIMIT),
		.divisor  (DVS_W'(peak_sq - RATED_SQ)),
		.quo      (div_quo),
		.busy     (div_busy),
		.done     (div_done)
	);

	always_comb begin
		rd_val = 32'h0000_0000;
		if (st.addr == OFS_CTRL) begin
			rd_val[EN_BIT] = st.cfg.enable;
		end else if (st.addr == OFS_CONT) begin
			rd_val[CUR_W-1:0] = st.cfg.cont_i;
		end else if (st.addr == OFS_PEAK) begin
			rd_val[CUR_W-1:0] = st.cfg.peak_i;
		end else if (st.addr == OFS_PTIME) begin
			rd_val[TIME_W-1:0] = st.cfg.peak_t;
		end else if (st.addr == OFS_ETIME) begin
			rd_val[TIME_W-1:0] = st.eff_t;
		end else if (st.addr == OFS_STAT) begin
			rd_val[FOLD_BIT] = st.folded;
			rd_val[BUSY_BIT] = st.rc != RC_IDLE;
		end else if (st.addr == OFS_ACC) begin
			rd_val[ACC_W-1:0] = acc;
		end
	end

	always_comb begin
		next_st = st;
		div_start = 1'b0;
		peak_sq = SQ_W'(st.cfg.peak_i) * SQ_W'(st.cfg.peak_i);
		// Quotient beyond the ceiling is cut before it can wrap
		allow_t = (div_quo > ACC_W'(TIME_MAX)) ? TIME_MAX : div_quo[TIME_W-1:0];

		// Allowed time recalculation
		case (st.rc)
			RC_KICK: begin
				// At or below rated current the allowed time is the TIME_MAX ceiling
				if (st.cfg.peak_i <= RATED_I) begin
					next_st.eff_t = (st.cfg.peak_t > TIME_MAX) ? TIME_MAX : st.cfg.peak_t;
					next_st.rc = RC_IDLE;
				end else if (!div_busy) begin
					div_start = 1'b1;
					next_st.rc = RC_RUN;
				end
			end
			RC_RUN: begin
				if (div_done) begin
					next_st.eff_t = (st.cfg.peak_t > allow_t) ? allow_t : st.cfg.peak_t;
					next_st.rc = RC_IDLE;
				end
			end
			default: begin
				next_st.rc = st.rc;
			end
		endcase

		// Write data phase, zero wait
		if (st.wr_pend) begin
			next_st.wr_pend = 1'b0;
			if (st.addr == OFS_CTRL) begin
				next_st.cfg.enable = HWDATA[EN_BIT];
			end else if (st.addr == OFS_CONT) begin
				next_st.cfg.cont_i = HWDATA[CUR_W-1:0];
			end else if (st.addr == OFS_PEAK) begin
				next_st.cfg.peak_i = (HWDATA > 32'(PEAK_MAX)) ? PEAK_MAX : HWDATA[CUR_W-1:0];
				next_st.rc = RC_KICK;
			end else if (st.addr == OFS_PTIME) begin
				next_st.cfg.peak_t = HWDATA[TIME_W-1:0];
				next_st.rc = RC_KICK;
			end
		end

		// Read data phase, one wait state so a prior write is seen
		if (st.rd_pend) begin
			next_st.rd_pend = 1'b0;
			next_st.hrdata = rd_val;
			next_st.hready = 1'b1;
		end

		// Address phase
		if (HSEL && HTRANS[1] && HREADY) begin
			next_st.addr = (HADDR[31:8] != 24'h00_0000) ? OFS_NONE : HADDR[7:0];
			if (HWRITE) begin
				next_st.wr_pend = HSIZE == HSIZE_WORD;
			end else begin
				next_st.rd_pend = 1'b1;
				next_st.hready = 1'b0;
			end
		end

		// Limit from the settings that take effect this edge
		next_st.folded = fold;
		if (!next_st.cfg.enable) begin
			next_st.ilim = '0;
		end else if (fold && next_st.cfg.cont_i < next_st.cfg.peak_i) begin
			next_st.ilim = next_st.cfg.cont_i;
		end else begin
			next_st.ilim = next_st.cfg.peak_i;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			st <= '0;
			st.cfg <= CFG_RST;
			st.rc <= RC_KICK;
			st.hready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign HRDATA    = st.hrdata;
	assign HREADYOUT = st.hready;
	assign HRESP     = st.hresp;
	assign I_LIMIT   = st.ilim;
	assign FOLDED    = st.folded;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	sequence s_peak_wr;
		HSEL && HTRANS[1] && HREADY && HWRITE && HSIZE == HSIZE_WORD && HADDR == 32'(OFS_PEAK);
	endsequence

	sequence s_calc_end;
		st.rc == RC_RUN && div_done;
	endsequence

	limit_cap_a: assert property (I_LIMIT <= st.cfg.peak_i)
		else $error("current limit above peak setting");
	peak_clamp_a: assert property (s_peak_wr ##1 HWDATA > 32'(PEAK_MAX) |=> st.cfg.peak_i == PEAK_MAX)
		else $error("peak setting not clamped");
	time_ceiling_a: assert property (st.eff_t <= TIME_MAX)
		else $error("effective time above ceiling");
	time_trim_a: assert property (s_calc_end and (allow_t < st.cfg.peak_t) |=> st.eff_t == $past(allow_t))
		else $error("long peak time not trimmed");
	time_keep_a: assert property (s_calc_end and (st.cfg.peak_t <= allow_t)
		|=> st.eff_t == $past(st.cfg.peak_t))
		else $error("short peak time altered");
	fold_limit_a: assert property (FOLDED && st.cfg.enable |-> I_LIMIT <= st.cfg.cont_i)
		else $error("folded limit above continuous setting");
	fold_release_a: assert property (!FOLDED && st.cfg.enable |-> I_LIMIT == st.cfg.peak_i)
		else $error("limit not back at peak setting");
	calc_bound_a: assert property (st.rc == RC_KICK && !div_busy |-> ##[1:30] st.rc != RC_RUN)
		else $error("allowed time not computed in time");
endmodule : pcf_top

// file: tb/pcf_phase_model.sv
// Phase current sensing model for the fold-back block.
// Assumes the regulator follows the demand, clipped to the current limit.
`timescale 1ns/1ps
module pcf_phase_model (
	input  wire logic                      clk,
	input  wire logic [pcf_pkg::CUR_W-1:0] demand,
	input  wire logic [pcf_pkg::CUR_W-1:0] limit,
	output logic [pcf_pkg::CUR_W-1:0]      cur
);
	import pcf_pkg::*;
	// One cycle regulator lag; never more than the granted limit
	always_ff @(posedge clk) begin
		cur <= (demand > limit) ? limit : demand;
	end
endmodule : pcf_phase_model

// file: tb/tb.sv
// Self-checking bench: AHB-Lite register access and fold-back runs.
// Assumes a short sample period so that a full fold fits in the run.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
	import pcf_pkg::*;
	localparam int SC = 4;
	logic              mclk;
	logic              sys_rst;
	logic              hsel;
	logic [31:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp;
	logic [CUR_W-1:0]  cur_meas;
	logic [CUR_W-1:0]  demand;
	logic [CUR_W-1:0]  i_limit;
	logic              folded;
	logic [31:0]       rdata;
	int                miscompares;
	int                n_checks;
	int                i;
	int                k;
	logic [31:0]       pk [8] = '{32'h100, 32'h14, 32'h14, 32'h0C, 32'h0D, 32'h0F, 32'h1E, 32'h14};
	logic [31:0]       pt [8] = '{32'h7D0, 32'h7D0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h64, 32'h7D0};

	pcf_top #(.SAMPLE_CYC(SC)) dut (
		.MCLK(mclk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .CUR_MEAS(cur_meas), .I_LIMIT(i_limit), .FOLDED(folded)
	);
	pcf_phase_model model (.clk(mclk), .demand(demand), .limit(i_limit), .cur(cur_meas));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic finish_test;
		$display("CHECKS %0d MISMATCHES %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// Bounded wait for hready; a hung slave ends the run
	task automatic wait_rdy;
		int j;
		for (j = 0; j < 50; j++) begin
			@(posedge mclk);
			if (hreadyout === 1'b1) break;
		end
		if (j == 50) begin
			miscompares++;
			finish_test();
		end
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
		@(posedge mclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {24'h000000, a};
		hsize  <= sz;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rdata = hrdata;
		`CHK(hresp, 1'b0)
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000, HSIZE_WORD);
		`CHK(rdata, e)
	endtask : rchk

	// Expected effective time from the fold-back arithmetic
	function automatic logic [31:0] etime_exp(input logic [31:0] p, input logic [31:0] t);
		logic [31:0] q;
		logic [31:0] e;
		q = (p > 32'd30) ? 32'd30 : p;
		e = (q <= 32'd12) ? 32'd30000 : 32'd1512000 / (q * q - 32'd144);
		if (e > 32'd30000) e = 32'd30000;
		if (t < e) e = t;
		return e;
	endfunction : etime_exp

	initial begin
		miscompares = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h00000000;
		demand = 8'h00;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (40) @(posedge mclk);
		`CHK(i_limit, 8'h00)
		rchk(OFS_CTRL, 32'h00000000);
		rchk(OFS_CONT, 32'h0000000A);
		rchk(OFS_PEAK, 32'h0000001E);
		rchk(OFS_ETIME, 32'h000007D0);
		bus(1'b1, 8'h1C, 32'hFFFFFFFF, HSIZE_WORD);
		rchk(8'h1C, 32'h00000000);
		bus(1'b1, OFS_ETIME, 32'h00001234, HSIZE_WORD);
		rchk(OFS_ETIME, 32'h000007D0);
		bus(1'b1, OFS_CONT, 32'h00000005, 3'h0);
		rchk(OFS_CONT, 32'h0000000A);
		$display("TEST registers done");
		for (k = 0; k < 8; k++) begin
			bus(1'b1, OFS_PEAK, pk[k], HSIZE_WORD);
			bus(1'b1, OFS_PTIME, pt[k], HSIZE_WORD);
			// Second write waits out the divider run of the first
			rchk(OFS_STAT, (pk[k] > 32'd12) ? 32'h00000002 : 32'h00000000);
			repeat (60) @(posedge mclk);
			rchk(OFS_PEAK, (pk[k] > 32'd30) ? 32'd30 : pk[k]);
			rchk(OFS_ETIME, etime_exp(pk[k], pt[k]));
		end
		$display("TEST peak time done");
		// Peak 20 A, demand 30 A: the model is clipped to the limit
		demand <= 8'h1E;
		bus(1'b1, OFS_CTRL, 32'h00000001, HSIZE_WORD);
		repeat (2 * SC + 2) @(posedge mclk);
		`CHK(i_limit, 8'h14)
		bus(1'b0, OFS_ACC, 32'h00000000, HSIZE_WORD);
		`CHK(rdata != 0 && rdata % 256 == 0, 1'b1)
		for (i = 0; i < 30000; i++) begin
			@(posedge mclk);
			`CHK(i_limit > 8'h14, 1'b0)
			if (folded === 1'b1) break;
		end
		if (i == 30000) begin
			miscompares++;
			finish_test();
		end
		@(posedge mclk);
		`CHK(i_limit, 8'h0A)
		rchk(OFS_ACC, 32'd1512000);
		rchk(OFS_STAT, 32'h00000001);
		repeat (3 * SC) @(posedge mclk);
		rchk(OFS_ACC, 32'd1512000);
		$display("TEST fold done");
		demand <= 8'h05;
		for (i = 0; i < 3 * SC + 4; i++) begin
			@(posedge mclk);
			if (folded === 1'b0) break;
		end
		`CHK(folded, 1'b0)
		repeat (2) @(posedge mclk);
		`CHK(i_limit, 8'h14)
		bus(1'b0, OFS_ACC, 32'h00000000, HSIZE_WORD);
		`CHK((32'd1512000 - rdata) % 75, 32'd0)
		// Raised continuous setting speeds the drain to zero
		bus(1'b1, OFS_CONT, 32'h0000001E, HSIZE_WORD);
		for (i = 0; i < 4000; i++) begin
			bus(1'b0, OFS_ACC, 32'h00000000, HSIZE_WORD);
			if (rdata === 32'h00000000) break;
		end
		`CHK(rdata, 32'h00000000)
		repeat (3 * SC) @(posedge mclk);
		rchk(OFS_ACC, 32'h00000000);
		bus(1'b1, OFS_CTRL, 32'h00000000, HSIZE_WORD);
		repeat (2) @(posedge mclk);
		`CHK(i_limit, 8'h00)
		$display("TEST release done");
		finish_test();
	end
endmodule : tb
